/* File: hdl/fifo_irq_source_config.sv */
// fifo depth, trigger level and interrupt line routing for the data handler
`timescale 1ns/1ps

// How it works
// - depth code 00..11 gives fifo capacity 16, 32, 48 or 64 bytes
// - trigger field B means a trigger level of B plus one bytes
// - level-reached source goes high once fifo count reaches trigger level
// - rx/standby line0 routing for continuous and buffered modes
// - packet mode line0: payload ready, byte, not-empty, sync or address match
// - line1: bit clock in continuous, else none/full/rssi/level, packet 00 crc ok
// - fifo-derived sources stay routed while the device is in standby
// - launch bit 0 starts transmit at trigger level, line0 shows level
// - launch bit 1 starts transmit when non-empty, line0 shows not-empty
// - data mode 00 continuous, 01 buffered, 1x packet
// - fifo-full source high while the fifo holds its capacity
// - not-empty source high while fifo holds data, low when empty
module fifo_irq_source_config
    import irq_route_pkg::*;
(
    input  wire logic          clock_in,
    input  wire logic          rstn_in,
    input  wire logic [7:0]    addr_in,
    input  wire logic [7:0]    wdata_in,
    input  wire logic          wr_in,
    input  wire logic          rd_in,
    output logic      [7:0]    rdata_out,
    input  wire radio_events_t events_in,
    input  wire fifo_access_t  fifo_in,
    output logic               irq_line0_out,
    output logic               irq_line1_out,
    output logic               tx_start_out,
    output logic               fifo_full_out,
    output logic               fifo_not_empty_out,
    output logic               level_reached_out,
    output logic               interrupt_out
);

    logic [7:0]         depth_trig_reg;
    logic [7:0]         routing_reg;
    logic [7:0]         mode_reg;
    logic [ev_w-1:0]    status_reg;
    logic [ev_w-1:0]    enable_reg;
    logic [count_w-1:0] count_reg;
    logic [count_w-1:0] count_next;
    logic [count_w-1:0] capacity;
    logic [count_w-1:0] level;
    logic               full_now;
    logic               level_now;
    logic               not_empty_now;
    logic               push_ok;
    logic               pop_ok;
    logic               line0_next;
    logic               line1_next;
    logic               start_next;
    logic [ev_w-1:0]    events;
    logic [ev_w-1:0]    clear_bits;
    data_mode_t         dmode;
    op_mode_t           op;

    assign capacity      = fifo_capacity(depth_trig_reg[depth_hi:depth_lo]);
    assign level         = trigger_level(depth_trig_reg[trig_hi:trig_lo]);
    assign dmode         = decode_data_mode(mode_reg[dmode_hi:dmode_lo]);
    assign op            = op_mode_t'(mode_reg[op_hi:op_lo]);
    // >= keeps full honest if software shrinks the depth below the fill
    assign full_now      = (count_reg >= capacity);
    assign level_now     = (count_reg >= level);
    assign not_empty_now = (count_reg != count_zero);
    assign push_ok       = fifo_in.push && !full_now;
    assign pop_ok        = fifo_in.pop && not_empty_now;

    // register writes
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            depth_trig_reg <= fifo_depth_and_trigger_rst;
            routing_reg    <= interrupt_routing_select_rst;
            mode_reg       <= mode_control_rst;
            enable_reg     <= irq_enable_rst;
        end else if (wr_in) begin
            unique case (addr_in)
                fifo_depth_and_trigger_addr:   depth_trig_reg <= wdata_in;
                interrupt_routing_select_addr: routing_reg <= wdata_in;
                mode_control_addr:             mode_reg <= wdata_in;
                irq_enable_addr:               enable_reg <= wdata_in[ev_w-1:0];
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                fifo_depth_and_trigger_addr:   rdata_out <= depth_trig_reg;
                interrupt_routing_select_addr: rdata_out <= {routing_reg[7:2], fifo_full_out, fifo_not_empty_out};
                mode_control_addr:             rdata_out <= mode_reg;
                irq_status_addr:               rdata_out <= {4'h0, status_reg};
                irq_enable_addr:               rdata_out <= {4'h0, enable_reg};
                default:                       rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // fifo byte count
    always_comb begin
        count_next = count_reg;
        if (push_ok && !pop_ok) begin
            count_next = count_reg + count_one;
        end else if (pop_ok && !push_ok) begin
            count_next = count_reg - count_one;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            count_reg <= count_zero;
        end else begin
            count_reg <= count_next;
        end
    end

    // fifo-derived source flags
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            fifo_full_out      <= 1'b0;
            fifo_not_empty_out <= 1'b0;
            level_reached_out  <= 1'b0;
        end else begin
            fifo_full_out      <= full_now;
            fifo_not_empty_out <= not_empty_now;
            level_reached_out  <= level_now;
        end
    end

    // line routing
    always_comb begin
        line0_next = 1'b0;
        line1_next = 1'b0;
        start_next = 1'b0;
        if (op == op_transmit) begin
            if (routing_reg[launch_bit]) begin
                line0_next = not_empty_now;
                start_next = not_empty_now;
            end else begin
                line0_next = level_now;
                start_next = level_now;
            end
            if (dmode == dm_continuous) begin
                line1_next = events_in.recovered_bit_clock;
            end else begin
                line1_next = routing_reg[tx_sel1_bit] ? events_in.tx_done : full_now;
            end
        end else if (op == op_receive || op == op_standby) begin
            unique case (dmode)
                dm_continuous: begin
                    // in continuous mode no source reaches the lines in standby
                    if (op == op_receive) begin
                        line0_next = (routing_reg[sel0_hi:sel0_lo] == sel_01) ?
                                     events_in.rssi_above : events_in.sync_found;
                        line1_next = events_in.recovered_bit_clock;
                    end
                end
                dm_buffered, dm_packet: begin
                    unique case (routing_reg[sel0_hi:sel0_lo])
                        sel_00: line0_next = (op == op_receive) && (dmode == dm_packet) &&
                                             events_in.payload_ready;
                        sel_01: line0_next = (op == op_receive) && events_in.write_byte;
                        sel_10: line0_next = not_empty_now;
                        sel_11: line0_next = (op == op_receive) &&
                                             ((dmode == dm_packet && mode_reg[filter_bit]) ?
                                              events_in.addr_match : events_in.sync_found);
                    endcase
                    unique case (routing_reg[sel1_hi:sel1_lo])
                        sel_00: line1_next = (op == op_receive) && (dmode == dm_packet) &&
                                             events_in.crc_ok;
                        sel_01: line1_next = full_now;
                        sel_10: line1_next = (op == op_receive) && events_in.rssi_above;
                        sel_11: line1_next = level_now;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            irq_line0_out <= 1'b0;
            irq_line1_out <= 1'b0;
            tx_start_out  <= 1'b0;
        end else begin
            irq_line0_out <= line0_next;
            irq_line1_out <= line1_next;
            tx_start_out  <= start_next;
        end
    end

    // sticky status; a set in the clearing cycle survives
    assign events[ev_level]    = level_now && !level_reached_out;
    assign events[ev_full]     = full_now && !fifo_full_out;
    assign events[ev_overflow] = fifo_in.push && full_now;
    assign events[ev_tx_start] = start_next && !tx_start_out;
    assign clear_bits          = (wr_in && addr_in == irq_clear_addr) ? wdata_in[ev_w-1:0] : 4'h0;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            status_reg    <= 4'h0;
            interrupt_out <= 1'b0;
        end else begin
            status_reg    <= (status_reg & ~clear_bits) | events;
            interrupt_out <= |(((status_reg & ~clear_bits) | events) & enable_reg);
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    chk_full_holds_count: assert property (
        full_now && fifo_in.push && !fifo_in.pop |=> count_reg == $past(count_reg))
        else $error("count grew past capacity");
    chk_level_plus_one: assert property (
        count_reg == level |=> level_reached_out)
        else $error("level not reached at trigger plus one");
    chk_level_below: assert property (
        count_reg < level ##1 !$rose(count_reg >= level) |-> !level_reached_out)
        else $error("level flagged below trigger");
    chk_cont_rssi_route: assert property (
        op == op_receive && dmode == dm_continuous && routing_reg[sel0_hi:sel0_lo] == sel_01
        |=> irq_line0_out == $past(events_in.rssi_above))
        else $error("continuous line0 not rssi");
    chk_packet_addr_route: assert property (
        op == op_receive && dmode == dm_packet && mode_reg[filter_bit] &&
        routing_reg[sel0_hi:sel0_lo] == sel_11 |=> irq_line0_out == $past(events_in.addr_match))
        else $error("packet line0 not address match");
    chk_bitclk_route: assert property (
        op == op_receive && dmode == dm_continuous |=> irq_line1_out == $past(events_in.recovered_bit_clock))
        else $error("line1 not bit clock");
    chk_standby_fifo: assert property (
        op == op_standby && dmode != dm_continuous && routing_reg[sel0_hi:sel0_lo] == sel_10
        |=> irq_line0_out == $past(not_empty_now))
        else $error("standby not-empty not routed");
    chk_launch_level: assert property (
        op == op_transmit && !routing_reg[launch_bit] |=> tx_start_out == $past(level_now) ##0
        irq_line0_out == tx_start_out)
        else $error("level launch wrong");
    chk_launch_nonempty: assert property (
        op == op_transmit && routing_reg[launch_bit] |=> tx_start_out == $past(not_empty_now))
        else $error("non-empty launch wrong");
    chk_empty_drops: assert property (
        count_reg == count_zero |=> !fifo_not_empty_out)
        else $error("not-empty stayed high");
    chk_unmapped_low: assert property (
        op == op_receive && dmode == dm_buffered && routing_reg[sel0_hi:sel0_lo] == sel_00 |=> !irq_line0_out)
        else $error("unmapped code drove line0");
    chk_depth_scale: assert property (
        capacity == {3'(depth_trig_reg[depth_hi:depth_lo]) + 3'h1, 4'h0})
        else $error("capacity not a multiple of sixteen");
    chk_read_latency: assert property (
        rd_in && addr_in == fifo_depth_and_trigger_addr |=> rdata_out == $past(depth_trig_reg))
        else $error("read data not one cycle after strobe");
    chk_level_status: assert property (
        events[ev_level] |=> status_reg[ev_level])
        else $error("level event lost from status");
    chk_sync_route: assert property (
        op == op_receive && dmode == dm_buffered && routing_reg[sel0_hi:sel0_lo] == sel_11
        |=> irq_line0_out == $past(events_in.sync_found))
        else $error("buffered line0 not sync");
    chk_payload_route: assert property (
        op == op_receive && dmode == dm_packet && routing_reg[sel0_hi:sel0_lo] == sel_00
        |=> irq_line0_out == $past(events_in.payload_ready))
        else $error("packet line0 not payload ready");
    chk_crc_route: assert property (
        op == op_receive && dmode == dm_packet && routing_reg[sel1_hi:sel1_lo] == sel_00
        |=> irq_line1_out == $past(events_in.crc_ok))
        else $error("packet line1 not crc ok");
    chk_standby_level: assert property (
        op == op_standby && dmode != dm_continuous && routing_reg[sel1_hi:sel1_lo] == sel_11
        |=> irq_line1_out == $past(level_now))
        else $error("standby level not routed");
    chk_standby_other: assert property (
        op == op_standby && dmode != dm_continuous && routing_reg[sel0_hi:sel0_lo] == sel_01 |=> !irq_line0_out)
        else $error("standby drove a receive-only source");
    chk_cont_standby_quiet: assert property (
        op == op_standby && dmode == dm_continuous |=> !irq_line0_out && !irq_line1_out)
        else $error("continuous standby drove a line");
    chk_mode_decode: assert property (
        ((mode_reg[dmode_hi:dmode_lo] == sel_00) == (dmode == dm_continuous)) &&
        ((mode_reg[dmode_hi:dmode_lo] == sel_01) == (dmode == dm_buffered)))
        else $error("data mode decoded wrongly");
    chk_full_flag: assert property (
        count_reg == capacity |=> fifo_full_out)
        else $error("full flag missing at capacity");
    chk_full_below: assert property (
        count_reg < capacity |=> !fifo_full_out)
        else $error("full flag below capacity");
    chk_overflow_status: assert property (
        fifo_in.push && full_now |=> status_reg[ev_overflow])
        else $error("overflow not recorded");
    chk_not_empty_set: assert property (
        count_reg != count_zero |=> fifo_not_empty_out)
        else $error("not-empty missing with data held");
    chk_line1_unmapped: assert property (
        op == op_receive && dmode == dm_buffered && routing_reg[sel1_hi:sel1_lo] == sel_00 |=> !irq_line1_out)
        else $error("unmapped code drove line1");

    cov_fifo_full:   cover property (fifo_in.push ##1 fifo_full_out);
    cov_tx_launch:   cover property ($rose(tx_start_out));
    cov_irq_raised:  cover property ($rose(interrupt_out));
    cov_standby_lvl: cover property (op == op_standby && irq_line1_out);
    cov_overflow:    cover property (events[ev_overflow]);

endmodule // fifo_irq_source_config

/* File: pkg/irq_route_pkg.sv */
// constants, types and helpers for the fifo interrupt routing block
package irq_route_pkg;

    // register offsets
    localparam logic [7:0] fifo_depth_and_trigger_addr   = 8'h0c;
    localparam logic [7:0] interrupt_routing_select_addr = 8'h0d;
    localparam logic [7:0] mode_control_addr             = 8'h20;
    localparam logic [7:0] irq_status_addr               = 8'h21;
    localparam logic [7:0] irq_clear_addr                = 8'h22;
    localparam logic [7:0] irq_enable_addr               = 8'h23;

    // reset values
    localparam logic [7:0] fifo_depth_and_trigger_rst   = 8'h0f;
    localparam logic [7:0] interrupt_routing_select_rst = 8'h00;
    localparam logic [7:0] mode_control_rst             = 8'h00;
    localparam logic [3:0] irq_enable_rst               = 4'h0;

    // field positions
    localparam int depth_hi      = 7;
    localparam int depth_lo      = 6;
    localparam int trig_hi       = 5;
    localparam int trig_lo       = 0;
    localparam int sel0_hi       = 7;
    localparam int sel0_lo       = 6;
    localparam int sel1_hi       = 5;
    localparam int sel1_lo       = 4;
    localparam int launch_bit    = 3;
    localparam int tx_sel1_bit   = 2;
    localparam int full_bit      = 1;
    localparam int not_empty_bit = 0;
    localparam int dmode_hi      = 7;
    localparam int dmode_lo      = 6;
    localparam int filter_bit    = 2;
    localparam int op_hi         = 1;
    localparam int op_lo         = 0;

    // fifo sizing
    localparam int             count_w      = 7;
    localparam logic [6:0]     depth_step   = 7'h10;
    localparam logic [6:0]     count_zero   = 7'h00;
    localparam logic [6:0]     count_one    = 7'h01;

    // interrupt event bits
    localparam int ev_level    = 0;
    localparam int ev_full     = 1;
    localparam int ev_overflow = 2;
    localparam int ev_tx_start = 3;
    localparam int ev_w        = 4;

    // source selector codes
    localparam logic [1:0] sel_00 = 2'h0;
    localparam logic [1:0] sel_01 = 2'h1;
    localparam logic [1:0] sel_10 = 2'h2;
    localparam logic [1:0] sel_11 = 2'h3;

    typedef enum logic [1:0] {op_standby, op_receive, op_transmit, op_sleep} op_mode_t;
    typedef enum {dm_continuous, dm_buffered, dm_packet} data_mode_t;

    // events from the radio datapath, all levels except write_byte
    typedef struct packed {
        logic sync_found;
        logic rssi_above;
        logic write_byte;
        logic payload_ready;
        logic crc_ok;
        logic addr_match;
        logic recovered_bit_clock;
        logic tx_done;
    } radio_events_t;

    typedef struct packed {
        logic       push;
        logic       pop;
    } fifo_access_t;

    // usable capacity in bytes for the two-bit depth code
    function automatic logic [6:0] fifo_capacity(input logic [1:0] code);
        fifo_capacity = 7'((code + 7'h01) * depth_step);
    endfunction

    // trigger level in bytes is the field value plus one
    function automatic logic [6:0] trigger_level(input logic [5:0] b);
        trigger_level = 7'({1'b0, b} + count_one);
    endfunction

    function automatic data_mode_t decode_data_mode(input logic [1:0] code);
        if (code[1]) begin
            decode_data_mode = dm_packet;
        end else if (code[0]) begin
            decode_data_mode = dm_buffered;
        end else begin
            decode_data_mode = dm_continuous;
        end
    endfunction

endpackage

/* File: tb/host_irq_watch.sv */
// host model that watches line0 and the interrupt output and counts their rising edges
`timescale 1ns/1ps
module host_irq_watch (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic        line0_in,
    input  wire logic        irq_in,
    output logic      [15:0] line0_rises_out,
    output logic      [15:0] irq_rises_out
);
    logic line0_reg;
    logic irq_reg;

    // the host samples on the same clock as the device, so only edges are counted, not levels
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            line0_reg       <= 1'b0;
            irq_reg         <= 1'b0;
            line0_rises_out <= 16'h0000;
            irq_rises_out   <= 16'h0000;
        end else begin
            line0_reg <= line0_in;
            irq_reg   <= irq_in;
            if (line0_in && !line0_reg) begin
                line0_rises_out <= line0_rises_out + 16'h0001;
            end
            if (irq_in && !irq_reg) begin
                irq_rises_out <= irq_rises_out + 16'h0001;
            end
        end
    end
endmodule // host_irq_watch

/* File: tb/tb_fifo_irq_source_config.sv */
// self-checking bench for fifo depth, trigger level and interrupt routing
`timescale 1ns/1ps
module tb_fifo_irq_source_config;
    import irq_route_pkg::*;
    logic          clock_in, rstn_in, wr_in, rd_in;
    logic [7:0]    addr_in, wdata_in, rdata_out, rv;
    radio_events_t events_in;
    fifo_access_t  fifo_in;
    logic          line0, line1, tx_start, full, ne, lvl, irq, f;
    logic [15:0]   l0_rises, irq_rises, l0_base;
    int            n_mismatch, n_checks, cnt, cap;
    logic [7:0]    ra [7] = '{8'h0c, 8'h0d, 8'h20, 8'h21, 8'h22, 8'h23, 8'hff};
    logic [7:0]    rx [7] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int            tgt [4] = '{0, 9, 10, 16};

    fifo_irq_source_config i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .events_in(events_in),
        .fifo_in(fifo_in), .irq_line0_out(line0), .irq_line1_out(line1), .tx_start_out(tx_start),
        .fifo_full_out(full), .fifo_not_empty_out(ne), .level_reached_out(lvl), .interrupt_out(irq));
    host_irq_watch i_host (.clock_in(clock_in), .rstn_in(rstn_in), .line0_in(line0), .irq_in(irq),
        .line0_rises_out(l0_rises), .irq_rises_out(irq_rises));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic settle();
        repeat (2) @(posedge clock_in);
        #1;
    endtask

    // n must be above zero, else the access would be raised and dropped in one step
    task automatic move(input int n, input fifo_access_t op);
        @(posedge clock_in);
        fifo_in <= op;
        repeat (n) @(posedge clock_in);
        fifo_in <= 2'b00;
        settle();
    endtask

    function automatic logic [1:0] exp_lines(input logic [1:0] dm, input logic rx_on, input logic filt,
                                             input logic [3:0] s, input radio_events_t e,
                                             input logic fl, input logic nz, input logic lv);
        logic a;
        logic b;
        if (dm == 2'b00) begin
            a = (s[3:2] == 2'b01) ? e.rssi_above : e.sync_found;
            b = e.recovered_bit_clock;
            if (!rx_on) begin
                a = 1'b0;
                b = 1'b0;
            end
        end else begin
            case (s[3:2])
                2'b00:   a = dm[1] ? e.payload_ready : 1'b0;
                2'b01:   a = e.write_byte;
                2'b10:   a = nz;
                default: a = (dm[1] && filt) ? e.addr_match : e.sync_found;
            endcase
            case (s[1:0])
                2'b00:   b = dm[1] ? e.crc_ok : 1'b0;
                2'b01:   b = fl;
                2'b10:   b = e.rssi_above;
                default: b = lv;
            endcase
            // standby keeps only the fifo-derived selections
            if (!rx_on && s[3:2] != 2'b10) a = 1'b0;
            if (!rx_on && s[0] != 1'b1) b = 1'b0;
        end
        return {a, b};
    endfunction

    task automatic test_done();
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        rstn_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 8'h00; wdata_in = 8'h00;
        events_in = 8'h00; fifo_in = 2'b00;
        void'($urandom(70942));
        repeat (3) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], rv);
            chk("reset read", rv, rx[i]);
        end
        for (int d = 0; d < 4; d++) begin
            cap = 16 * (d + 1);
            wr(8'h0c, {d[1:0], 6'h3f});
            move(cap - 1, 2'b10);
            chk("full below cap", {7'h00, full}, 8'h00);
            chk("not empty", {7'h00, ne}, 8'h01);
            move(2, 2'b10);
            chk("full at cap", {7'h00, full}, 8'h01);
            rd(8'h21, rv);
            chk("full and overflow status", rv & 8'h06, 8'h06);
            rd(8'h0d, rv);
            chk("live flags", rv & 8'h03, 8'h03);
            wr(8'h22, 8'h0f);
            move(70, 2'b01);
            chk("drained", {6'h00, full, ne}, 8'h00);
        end
        cnt = 0;
        wr(8'h0c, 8'h09);
        for (int t = 0; t < 4; t++) begin
            if (tgt[t] > cnt) move(tgt[t] - cnt, 2'b10);
            else settle();
            cnt = tgt[t];
            chk("fill flags", {5'h00, lvl, full, ne}, {5'h00, cnt >= 10, cnt >= 16, cnt != 0});
            for (int dm = 0; dm < 4; dm++) begin
                for (int op = 0; op < 2; op++) begin
                    for (int s = 0; s < 16; s++) begin
                        f = 1'($urandom);
                        wr(8'h20, {dm[1:0], 3'b000, f, 1'b0, op[0]});
                        wr(8'h0d, {s[3:0], 4'h0});
                        @(posedge clock_in);
                        events_in <= 8'($urandom);
                        settle();
                        @(posedge clock_in);
                        #1 chk("lines", {6'h00, line0, line1}, {6'h00, exp_lines(dm[1:0], op[0], f, s[3:0],
                            events_in, cnt >= 16, cnt != 0, cnt >= 10)});
                    end
                end
            end
            for (int l = 0; l < 8; l++) begin
                wr(8'h20, {1'b0, ~l[2], 6'h02});
                wr(8'h0d, {4'h0, l[0], l[1], 2'b00});
                events_in <= 8'($urandom);
                settle();
                @(posedge clock_in);
                #1 chk("transmit", {5'h00, line0, tx_start, line1}, {5'h00, l[0] ? cnt != 0 : cnt >= 10,
                    l[0] ? cnt != 0 : cnt >= 10, l[2] ? events_in.recovered_bit_clock :
                    (l[1] ? events_in.tx_done : cnt >= 16)});
            end
        end
        wr(8'h20, 8'h00);
        wr(8'h22, 8'h0f);
        move(70, 2'b01);
        wr(8'h23, 8'h01);
        move(10, 2'b10);
        settle();
        chk("irq on level", {7'h00, irq}, 8'h01);
        rd(8'h21, rv);
        chk("level status", rv & 8'h01, 8'h01);
        wr(8'h23, 8'h00);
        settle();
        chk("irq masked", {7'h00, irq}, 8'h00);
        wr(8'h23, 8'h01);
        settle();
        chk("irq unmasked", {7'h00, irq}, 8'h01);
        wr(8'h22, 8'h01);
        settle();
        chk("irq cleared", {7'h00, irq}, 8'h00);
        rd(8'h21, rv);
        chk("status cleared", rv & 8'h01, 8'h00);
        chk("host irq rises", irq_rises[7:0], 8'h02);
        l0_base = l0_rises;
        wr(8'h20, 8'h40);
        wr(8'h0d, 8'h80);
        settle();
        chk("host line0 rises", l0_rises[7:0] - l0_base[7:0], 8'h01);
        test_done();
    end

    // whole run is about 5000 cycles; the margin covers a stuck handshake only
    initial begin
        repeat (30000) @(posedge clock_in);
        n_mismatch++;
        test_done();
    end
endmodule // tb_fifo_irq_source_config
